// >>> hw/sspl_pkg.sv
// package: constants and types of the strap / suspend pin block
package sspl_pkg;

  // ---------------------------------------------------------------
  // clock and reset timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int RESET_MIN_US    = 1;
  localparam int RESET_MIN_CYC   =
    (RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // pin synchroniser and capture window after reset release
  // ---------------------------------------------------------------
  localparam int          SYNC_STAGES = 2;
  localparam int          CAP_CNT_W   = 2;
  localparam logic [1:0]  CAP_LAST    = 2'h2;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFS_STATUS_CMD = 12'h000;
  localparam logic [11:0] OFS_CFG_TWO    = 12'h004;
  localparam logic [11:0] OFS_PIN_STATUS = 12'h008;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_ATTACH       = 0;
  localparam int BIT_DYN_POWER    = 0;
  localparam int BIT_SELF_DEFAULT = 1;
  localparam int ST_STRAP_LSB     = 0;
  localparam int ST_MGMT_CFG      = 2;
  localparam int ST_SENSE         = 3;
  localparam int ST_SELF_POWERED  = 4;
  localparam int ST_STRAP_RSVD    = 5;
  localparam int ST_FIXED_LSB     = 6;
  localparam int ST_STRAP_VALID   = 8;
  localparam int ST_INDICATOR     = 9;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic       RST_ATTACH       = 1'b0;
  localparam logic       RST_DYN_POWER    = 1'b0;
  localparam logic       RST_SELF_DEFAULT = 1'b0;
  localparam logic [1:0] RST_STRAP        = 2'h0;
  localparam logic [1:0] RST_CAP_CNT      = 2'h0;
  localparam logic [31:0] RST_RDATA       = 32'h0000_0000;

  // ---------------------------------------------------------------
  // fixed-port strap encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] STRAP_ALL_REMOVABLE = 2'h0;
  localparam logic [1:0] STRAP_PORT1_FIXED   = 2'h1;
  localparam logic [1:0] STRAP_PORTS12_FIXED = 2'h2;
  localparam logic [1:0] STRAP_RESERVED      = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_CAPTURE = 2'h0,
    ST_RUN     = 2'h1
  } sspl_state_t;

  typedef enum logic [1:0] {
    SEL_STATUS_CMD = 2'h0,
    SEL_CFG_TWO    = 2'h1,
    SEL_PIN_STATUS = 2'h2,
    SEL_NONE       = 2'h3
  } sspl_sel_t;

endpackage : sspl_pkg

// >>> hw/sspl_strap_suspend_pin.sv
// multifunction strap / indicator / power-sense pin with apb registers
//
// Summary of operation
// R1 - indicator high only when configured and active
// R2 - dynamic power bit selects sense for report
// R3 - sense sampled at reset, before attach
// R4 - sense changes ignored once attach set
// R5 - sense low bus-powered, high self-powered
// R6 - sense role only with management-bus config
// R7 - strap during reset, indicator afterwards
// R8 - two-bit fixed-port strap sampled at release
// R9 - 00 none, 01 port1, 10 ports1-2, 11 reserved
// R10 - config-method select latched at reset release
// R11 - system holds reset low at least 1 us
// R12 - sampled straps held until next reset
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
module sspl_strap_suspend_pin
  import sspl_pkg::*;
(
  input  wire logic              pclk,            // core clock, 50 MHz
  input  wire logic              presetn,         // async reset, low
  // apb slave
  input  wire logic              psel,            // slave select
  input  wire logic              penable,         // access phase
  input  wire logic              pwrite,          // write when high
  input  wire logic [ADDR_W-1:0] paddr,           // byte address
  input  wire logic [31:0]       pwdata,          // write data
  output logic      [31:0]       prdata,          // read data
  output logic                   pready,          // transfer done
  output logic                   pslverr,         // unmapped address
  // hub core state, same clock
  input  wire logic              hub_configured,  // hub configured
  input  wire logic              hub_suspended,   // hub in suspend
  // pins
  input  wire logic              activity_in,     // shared pin level
  output logic                   activity_out,    // indicator drive
  output logic                   activity_oe,     // indicator enable
  input  wire logic              fixed_port_strap_hi, // partner strap
  input  wire logic              config_select_in,    // config method
  // results
  output logic                   self_powered,    // reported power
  output logic      [1:0]        fixed_port_mask, // ports 2..1 fixed
  output logic                   strap_reserved,  // strap code 11
  output logic                   mgmt_configured, // mgmt-bus method
  output logic                   strap_valid      // straps captured
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    sspl_state_t          state;
    logic [CAP_CNT_W-1:0] cap_cnt;
    logic [1:0]           fixed_port_strap;
    logic [1:0]           fixed_mask;
    logic                 strap_rsvd;
    logic                 mgmt_cfg;
    logic                 sense;
    logic                 attach;
    logic                 dyn_power;
    logic                 self_default;
    logic                 self_pwr;
    logic                 ind;
    logic                 ind_oe;
    logic [31:0]          rdata;
  } sspl_regs_t;

  // straps and method read low until captured
  localparam sspl_regs_t REGS_RESET = '{
    state:            ST_CAPTURE,
    cap_cnt:          RST_CAP_CNT,
    fixed_port_strap: RST_STRAP,
    fixed_mask:       RST_STRAP,
    strap_rsvd:       1'b0,
    mgmt_cfg:         1'b0,
    sense:            1'b0,
    attach:           RST_ATTACH,
    dyn_power:        RST_DYN_POWER,
    self_default:     RST_SELF_DEFAULT,
    self_pwr:         RST_SELF_DEFAULT,
    ind:              1'b0,
    ind_oe:           1'b0,
    rdata:            RST_RDATA
  };

  sspl_regs_t cur;
  sspl_regs_t next_cur;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pins_s;
  logic       fixed_port_strap_lo_s;
  logic       sense_s;
  logic       strap_hi_s;
  logic       cfg_sel_s;
  logic [1:0] strap_now;

  // stages reset low, so capture waits until both have filled
  sspl_sync #(
    .WIDTH (3)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_async ({config_select_in, fixed_port_strap_hi, activity_in}),
    .q_sync  (pins_s)
  );

  // the shared pin is the strap during capture, the sense afterwards in management mode
  assign fixed_port_strap_lo_s = pins_s[0];
  assign sense_s               = pins_s[0];
  assign strap_hi_s            = pins_s[1];
  assign cfg_sel_s             = pins_s[2];
  assign strap_now             = {strap_hi_s, fixed_port_strap_lo_s};

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic sspl_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    sspl_sel_t s;
    s = SEL_NONE;
    unique case (a)
      OFS_STATUS_CMD: s = SEL_STATUS_CMD;
      OFS_CFG_TWO:    s = SEL_CFG_TWO;
      OFS_PIN_STATUS: s = SEL_PIN_STATUS;
      default:        s = SEL_NONE;
    endcase
    return s;
  endfunction : reg_sel

  // strap code to ports 2..1 fixed mask
  function automatic logic [1:0] fixed_decode(input logic [1:0] code);
    logic [1:0] m;
    m = 2'h0;
    unique case (code)
      STRAP_ALL_REMOVABLE: m = 2'h0;
      STRAP_PORT1_FIXED:   m = 2'h1;
      STRAP_PORTS12_FIXED: m = 2'h3;
      STRAP_RESERVED:      m = 2'h0;
    endcase
    return m;
  endfunction : fixed_decode

  // code 11 carries no port mask and is flagged instead
  function automatic logic strap_is_reserved(input logic [1:0] code);
    return (code == STRAP_RESERVED);
  endfunction : strap_is_reserved

  // the pin is an output only in strap mode after capture
  function automatic logic drives_pin(input sspl_regs_t r);
    return (r.state == ST_RUN) && !r.mgmt_cfg;
  endfunction : drives_pin

  // reported power: sense in dynamic management mode, else default
  function automatic logic power_report(input sspl_regs_t r);
    logic p;
    p = r.self_default;
    if (r.mgmt_cfg && r.dyn_power) begin                   // [R2] [R6]
      p = r.sense;                                         // [R5]
    end
    return p;
  endfunction : power_report

  // read word of one register, built in the setup phase
  function automatic logic [31:0] read_word(input sspl_sel_t  s,
                                            input sspl_regs_t r);
    logic [31:0] w;
    w = RST_RDATA;
    unique case (s)
      SEL_STATUS_CMD: begin
        w[BIT_ATTACH] = r.attach;
      end
      SEL_CFG_TWO: begin
        w[BIT_DYN_POWER]    = r.dyn_power;
        w[BIT_SELF_DEFAULT] = r.self_default;
      end
      SEL_PIN_STATUS: begin
        w[ST_STRAP_LSB +: 2] = r.fixed_port_strap;
        w[ST_MGMT_CFG]       = r.mgmt_cfg;
        w[ST_SENSE]          = r.sense;
        w[ST_SELF_POWERED]   = r.self_pwr;
        w[ST_STRAP_RSVD]     = r.strap_rsvd;
        w[ST_FIXED_LSB +: 2] = r.fixed_mask;
        w[ST_STRAP_VALID]    = (r.state == ST_RUN);
        w[ST_INDICATOR]      = r.ind;
      end
      SEL_NONE: begin
        w = RST_RDATA;
      end
    endcase
    return w;
  endfunction : read_word

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  sspl_sel_t sel;
  logic      setup_ph;
  logic      wr_done;
  logic      run;

  assign sel      = reg_sel(paddr);
  assign setup_ph = psel & ~penable;
  assign wr_done  = psel & penable & pwrite;
  assign run      = (cur.state == ST_RUN);
  // zero wait states: every access ends in its first access-phase cycle
  assign pready   = psel & penable;
  assign pslverr  = psel & penable & (sel == SEL_NONE);

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_cur = cur;

    unique case (cur.state)
      ST_CAPTURE: begin
        // wait for the synchronisers to fill, then sample once
        if (cur.cap_cnt == CAP_LAST) begin
          next_cur.fixed_port_strap = strap_now;           // [R8]
          next_cur.fixed_mask       = fixed_decode(strap_now); // [R9]
          next_cur.strap_rsvd       = strap_is_reserved(strap_now); // [R9]
          next_cur.mgmt_cfg         = cfg_sel_s;           // [R10]
          next_cur.sense            = sense_s;             // [R3]
          next_cur.state    = ST_RUN;
        end else begin
          next_cur.cap_cnt = cur.cap_cnt + 1'b1;
        end
      end
      ST_RUN: begin
        // sense follows the pin only until attach
        if (cur.mgmt_cfg && !cur.attach) begin              // [R6]
          next_cur.sense = sense_s;                        // [R3] [R4]
        end
      end
      // unused codes fall back to capture
      default: begin
        next_cur.state = ST_CAPTURE;
      end
    endcase

    // register writes, taken at the access edge
    if (wr_done) begin
      unique case (sel)
        SEL_STATUS_CMD: begin
          // attach only after capture; stays set until reset
          if (pwdata[BIT_ATTACH] && run) begin
            next_cur.attach = 1'b1;                        // [R4]
          end
        end
        SEL_CFG_TWO: begin
          next_cur.dyn_power    = pwdata[BIT_DYN_POWER];
          next_cur.self_default = pwdata[BIT_SELF_DEFAULT];
        end
        SEL_PIN_STATUS: begin
          // read only, write dropped
          next_cur.rdata = cur.rdata;
        end
        SEL_NONE: begin
          // unmapped, answered with an error
          next_cur.rdata = cur.rdata;
        end
      endcase
    end

    // power report: sense only in management mode with dynamic bit
    next_cur.self_pwr = power_report(cur);

    // indicator drive only in strap mode after capture
    next_cur.ind_oe = drives_pin(cur);                     // [R7]
    next_cur.ind    = drives_pin(cur) && hub_configured
                      && !hub_suspended;                   // [R1]

    // read data prepared in the setup phase
    if (setup_ph) begin
      next_cur.rdata = read_word(sel, cur);
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // straps are written only in capture, so they hold until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= REGS_RESET;                                   // [R12]
    end else begin
      cur <= next_cur;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata          = cur.rdata;
  assign activity_out    = cur.ind;
  assign activity_oe     = cur.ind_oe;
  assign self_powered    = cur.self_pwr;
  assign fixed_port_mask = cur.fixed_mask;
  assign strap_reserved  = cur.strap_rsvd;
  assign mgmt_configured = cur.mgmt_cfg;
  assign strap_valid     = run;

endmodule : sspl_strap_suspend_pin

// >>> hw/sspl_sync.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
module sspl_sync
  import sspl_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,    // core clock
  input  wire logic             presetn, // async reset, active low
  input  wire logic [WIDTH-1:0] d_async, // pin levels
  output logic      [WIDTH-1:0] q_sync   // levels in pclk domain
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] q;
  } sspl_sync_regs_t;

  sspl_sync_regs_t cur;
  sspl_sync_regs_t next_cur;

  // first stage read only by the second stage
  always_comb begin
    next_cur      = cur;
    next_cur.meta = d_async;
    next_cur.q    = cur.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign q_sync = cur.q;

endmodule : sspl_sync

// >>> tb/sspl_chk.sv
// checker: pin-role, strap and power-report relations at the ports
`timescale 1ns/10ps
module sspl_chk
  import sspl_pkg::*;
(
  input wire logic              pclk,            // core clock
  input wire logic              presetn,         // async reset, low
  input wire logic              psel,            // apb select
  input wire logic              penable,         // apb access
  input wire logic              pwrite,          // apb write
  input wire logic [ADDR_W-1:0] paddr,           // apb address
  input wire logic [31:0]       pwdata,          // apb write data
  input wire logic              hub_configured,  // hub configured
  input wire logic              hub_suspended,   // hub suspended
  input wire logic              activity_in,     // shared pin level
  input wire logic              fixed_port_strap_hi, // partner strap
  input wire logic              config_select_in, // method pin
  input wire logic              activity_out,    // indicator drive
  input wire logic              activity_oe,     // indicator enable
  input wire logic              self_powered,    // reported power
  input wire logic [1:0]        fixed_port_mask, // fixed ports
  input wire logic              strap_reserved,  // code 11
  input wire logic              mgmt_configured, // mgmt method
  input wire logic              strap_valid      // straps captured
);
  logic       att_q;
  logic       dyn_q;
  logic       dflt_q;
  logic [1:0] cfg_age;
  logic       wr;
  assign wr = psel && penable && pwrite;
  // ---------------------------------------------------------------
  // shadow of attach and power config writes
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      att_q   <= 1'b0;
      dyn_q   <= 1'b0;
      dflt_q  <= 1'b0;
      cfg_age <= 2'h0;
    end else begin
      if (wr && paddr == OFS_STATUS_CMD && pwdata[0] && strap_valid)
        att_q <= 1'b1;
      if (wr && paddr == OFS_CFG_TWO) begin
        dyn_q   <= pwdata[0];
        dflt_q  <= pwdata[1];
        cfg_age <= 2'h0;
      end else if (cfg_age != 2'h3)
        cfg_age <= cfg_age + 2'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_ind_active: assert property (strap_valid && $past(strap_valid) &&
    !mgmt_configured |-> activity_out == $past(hub_configured && !hub_suspended))
    else $error("indicator does not follow hub state");
  a_oe_mode: assert property (strap_valid && $past(strap_valid)
    |-> activity_oe == !mgmt_configured)
    else $error("pin direction wrong for config method");
  a_oe_capture: assert property (!strap_valid |-> !activity_oe)
    else $error("pin driven during strap capture");
  a_strap_hold: assert property (strap_valid && $past(strap_valid)
    |-> $stable(fixed_port_mask) && $stable(mgmt_configured)
        && $stable(strap_reserved))
    else $error("captured straps changed");
  a_mask_decode: assert property (strap_valid
    |-> fixed_port_mask != 2'h2 && (!strap_reserved || fixed_port_mask == 2'h0))
    else $error("fixed port mask decode wrong");
  a_strap_sample: assert property ($rose(strap_valid) |->
    mgmt_configured == $past(config_select_in, 3) &&
    strap_reserved == ($past(activity_in, 3) &&
                       $past(fixed_port_strap_hi, 3)) &&
    fixed_port_mask[1] == ($past(fixed_port_strap_hi, 3) &&
                           !$past(activity_in, 3)))
    else $error("straps not taken from the pins at release");
  a_capture_time: assert property (!strap_valid |-> ##[0:4] strap_valid)
    else $error("straps not captured after reset release");
  a_attach_freeze: assert property (mgmt_configured && att_q &&
    $past(att_q, 2) && cfg_age == 2'h3 |-> $stable(self_powered))
    else $error("power report changed after attach");
  a_dyn_default: assert property (mgmt_configured && !dyn_q &&
    cfg_age == 2'h3 && $past(strap_valid) |-> self_powered == dflt_q)
    else $error("power report ignores default");
  c_ind_on: cover property (!mgmt_configured && activity_out);
  c_self_pwr: cover property (mgmt_configured && self_powered && att_q);
  c_reserved: cover property (strap_valid && strap_reserved);
endmodule : sspl_chk

bind sspl_strap_suspend_pin sspl_chk i_sspl_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .hub_configured, .hub_suspended,
  .activity_in, .fixed_port_strap_hi, .config_select_in,
  .activity_out, .activity_oe, .self_powered, .fixed_port_mask,
  .strap_reserved, .mgmt_configured, .strap_valid);

// >>> tb/sspl_pin_model.sv
// board side of the shared pin: strap resistors, lamp, power sense
`timescale 1ns/10ps
module sspl_pin_model (
  input  wire logic activity_out,        // device drive level
  input  wire logic activity_oe,         // device drives pin
  input  wire logic strap_lo,            // resistor on shared pin
  input  wire logic strap_hi,            // resistor on partner pin
  input  wire logic cfg_sel,             // method strap
  input  wire logic sense_level,         // local supply present
  output logic      activity_in,         // shared pin level
  output logic      fixed_port_strap_hi, // partner pin level
  output logic      config_select_in,    // method pin level
  output logic      lamp_on              // indicator lit
);
  // device owns the pin when it drives, else sense circuit in mgmt mode, else the resistor
  assign activity_in = activity_oe ? activity_out :
                       (cfg_sel ? sense_level : strap_lo);
  assign fixed_port_strap_hi = strap_hi;
  assign config_select_in    = cfg_sel;
  assign lamp_on             = activity_oe & activity_out;
endmodule : sspl_pin_model

// >>> tb/sspl_strap_suspend_pin_test.sv
// testbench: straps, indicator, power sense and apb access
`timescale 1ns/10ps
module sspl_strap_suspend_pin_test;
  import sspl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic hub_cfg, hub_susp, act_in, act_out, act_oe, s_hi, cfg_in, lamp;
  logic strap_lo, strap_hi, cfg_sel, sense, self_pwr, res, mgmt, valid, e;
  logic [1:0] mask;
  int failures, tests_run;
  sspl_strap_suspend_pin i_sspl_strap_suspend_pin (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .hub_configured(hub_cfg), .hub_suspended(hub_susp),
    .activity_in(act_in), .activity_out(act_out), .activity_oe(act_oe),
    .fixed_port_strap_hi(s_hi), .config_select_in(cfg_in),
    .self_powered(self_pwr), .fixed_port_mask(mask),
    .strap_reserved(res), .mgmt_configured(mgmt), .strap_valid(valid));
  sspl_pin_model i_sspl_pin_model (.activity_out(act_out),
    .activity_oe(act_oe), .strap_lo, .strap_hi, .cfg_sel,
    .sense_level(sense), .activity_in(act_in), .fixed_port_strap_hi(s_hi),
    .config_select_in(cfg_in), .lamp_on(lamp));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic stop_test;
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic do_reset(input logic lo, hi, cfg, sen);
    @(posedge pclk);
    presetn <= 1'b0; strap_lo <= lo; strap_hi <= hi; cfg_sel <= cfg;
    sense <= sen;
    repeat (RESET_MIN_CYC) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : do_reset
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_straps;
    logic [1:0] c, x;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      x = c == STRAP_PORT1_FIXED ? 2'h1 : c == STRAP_PORTS12_FIXED ? 2'h3 : 2'h0;
      do_reset(c[0], c[1], 1'b0, 1'b0);
      chk({res, mgmt, valid, mask}, {c == STRAP_RESERVED, 2'b01, x});
      strap_hi <= ~c[1];
      apb(1'b0, OFS_PIN_STATUS, 32'h0);
      chk(r & 32'h0000_01E7,
          {23'h0, 1'b1, x, c == STRAP_RESERVED, 3'h0, c});
      chk({30'h0, mask}, {30'h0, x});
    end
  endtask : t_straps
  task automatic t_indicator;
    for (int i = 0; i < 4; i++) begin
      hub_cfg <= i[1]; hub_susp <= i[0];
      repeat (3) @(posedge pclk);
      chk({act_oe, act_out, lamp}, {1'b1, {2{i[1] & ~i[0]}}});
    end
  endtask : t_indicator
  task automatic t_sense;
    do_reset(1'b0, 1'b0, 1'b1, 1'b1);
    apb(1'b0, OFS_PIN_STATUS, 32'h0);
    chk(r & 32'h0000_010C, 32'h0000_010C);
    chk({31'h0, act_oe}, 32'h0);
    apb(1'b1, OFS_CFG_TWO, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk({31'h0, self_pwr}, 32'h1);
    sense <= 1'b0;
    repeat (6) @(posedge pclk);
    chk({31'h0, self_pwr}, 32'h0);
    sense <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b1, OFS_STATUS_CMD, 32'h0000_0001);
    sense <= 1'b0;
    repeat (6) @(posedge pclk);
    chk({31'h0, self_pwr}, 32'h1);
    apb(1'b1, OFS_CFG_TWO, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk({31'h0, self_pwr}, 32'h0);
    apb(1'b1, OFS_CFG_TWO, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk({31'h0, self_pwr}, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask : t_sense
  // ---------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    failures = 0; tests_run = 0; presetn = 1'b0; psel = 1'b0;
    penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    hub_cfg = 1'b0; hub_susp = 1'b0; strap_lo = 1'b0; strap_hi = 1'b0;
    cfg_sel = 1'b0; sense = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_straps();
    t_indicator();
    t_sense();
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    stop_test();
  end
endmodule : sspl_strap_suspend_pin_test
